// ### hw/dec_dma_pkg.sv
// Shared constants for the decoder event link and its DMA sequencer
package dec_dma_pkg;
    localparam int EVT_RECEIVE = 30;
    localparam int EVT_TRANSMIT = 31;
    localparam int EVT_NULL_STALL = 29;
    localparam logic [31:0] CONFIG_BASE_ADDR = 32'h5000_0000;
    localparam logic [31:0] SYMBOL_MEM_ADDR = 32'h5001_0000;
    localparam logic [31:0] INTERLEAVER_MEM_ADDR = 32'h5005_0000;
    localparam logic [31:0] DECISION_MEM_ADDR = 32'h5006_0000;
    localparam logic [31:0] OUT_PARAM_ADDR = 32'h5000_0030;
    localparam logic [15:0] CONFIG_BYTES = 16'h0040;
    localparam logic [15:0] OUT_PARAM_BYTES = 16'h000c;
    localparam int BEAT_BYTES = 8;
    localparam int FL_W = 16;
    // Software register map of the sequencer (word offsets)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_FRAME = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_COUNT = 4'h3;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_INTERLEAVER_LOAD_FLAG_BIT = 1;
    localparam int CTRL_OUTPUT_PARAMS_FLAG_BIT = 2;
    localparam int CTRL_SHARED_BIT = 3;
    localparam int CTRL_FIRST_BIT = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_STALL_BIT = 2;
    localparam int STAT_PEND_BIT = 3;
    localparam int BEAT_CYCLES = 1;
    typedef enum logic [2:0] {
        XFER_CONFIG, XFER_SYMBOL, XFER_INTERLEAVE, XFER_APRIORI,
        XFER_DECISION, XFER_OUTPARAM, XFER_EXTRINSIC, XFER_DUMMY
    } xfer_kind_e;
    // Bytes moved per kind, always whole 8-byte beats
    function automatic logic [15:0] xfer_bytes(input xfer_kind_e k, input logic [FL_W-1:0] fl);
        logic [16:0] f;
        f = {1'b0, fl};
        case (k)
            XFER_CONFIG: xfer_bytes = CONFIG_BYTES;
            XFER_SYMBOL, XFER_APRIORI: xfer_bytes = 16'((f + 17'd1) >> 1) << 3;
            XFER_INTERLEAVE: xfer_bytes = 16'((f + 17'd6) >> 2) << 3;
            XFER_DECISION, XFER_EXTRINSIC: xfer_bytes = 16'((f + 17'd63) >> 6) << 3;
            XFER_OUTPARAM: xfer_bytes = OUT_PARAM_BYTES + 16'h0004;
            default: xfer_bytes = 16'h0000;
        endcase
    endfunction
endpackage

// ### hw/dec_dma_if.sv
// Link between decoder event source and the DMA sequencer
`timescale 1ns/1ps
interface dec_dma_if;
    logic decoder_transmit_request;
    logic decoder_receive_request;
    logic [31:0] addr;
    logic [63:0] wdata;
    logic [63:0] rdata;
    logic wr;
    logic rd;
    modport device (
        output decoder_transmit_request, decoder_receive_request, rdata,
        input addr, wdata, wr, rd
    );
    modport dma (
        input decoder_transmit_request, decoder_receive_request, rdata,
        output addr, wdata, wr, rd
    );
endinterface

// ### hw/dec_event_source.sv
// Decoder end: raises transmit and receive events and counts the target memories' beats
`timescale 1ns/1ps
module dec_event_source
    import dec_dma_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    dec_dma_if.device link,
    input wire logic decode_done_i,
    output logic [FL_W-1:0] frame_length_o,
    output logic interleaver_load_flag_o,
    output logic output_params_flag_o,
    output logic busy_o
);
    // =========================================
    // Sequence of expected transfers
    typedef enum {S_CFG, S_SYM, S_INT, S_RUN, S_HD, S_OUT, S_NEXT} dev_state_e;
    dev_state_e state_reg;
    logic [15:0] left_reg;
    logic xreq_reg;
    logic rreq_reg;
    logic [63:0] rdata_reg;
    logic cfg_lo_seen;
    logic in_win;
    logic out_win;
    assign in_win = link.wr && (link.addr[31:24] == CONFIG_BASE_ADDR[31:24]);
    assign out_win = link.rd && (link.addr[31:24] == CONFIG_BASE_ADDR[31:24]);
    assign cfg_lo_seen = in_win && (link.addr[15:0] == 16'h0000) && (state_reg == S_CFG);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= S_CFG;
            left_reg <= CONFIG_BYTES;
            xreq_reg <= 1'b1;
            rreq_reg <= 1'b0;
            frame_length_o <= '0;
            interleaver_load_flag_o <= 1'b0;
            output_params_flag_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            xreq_reg <= 1'b0;
            rreq_reg <= 1'b0;
            if (cfg_lo_seen) begin
                frame_length_o <= link.wdata[FL_W-1:0];
                interleaver_load_flag_o <= link.wdata[32];
                output_params_flag_o <= link.wdata[33];
            end
            if ((in_win || out_win) && left_reg != 16'h0000) begin
                left_reg <= left_reg - 16'(BEAT_BYTES);
                if (left_reg == 16'(BEAT_BYTES)) begin
                    unique case (state_reg)
                        S_CFG: begin
                            state_reg <= S_SYM;
                            left_reg <= xfer_bytes(XFER_SYMBOL, frame_length_o);
                            xreq_reg <= 1'b1; // [RULE_02] [RULE_21]
                        end
                        S_SYM: begin
                            if (interleaver_load_flag_o) begin
                                state_reg <= S_INT;
                                left_reg <= xfer_bytes(XFER_INTERLEAVE, frame_length_o);
                                xreq_reg <= 1'b1;
                            end else begin
                                state_reg <= S_RUN;
                                busy_o <= 1'b1;
                            end
                        end
                        S_INT: begin
                            state_reg <= S_RUN;
                            busy_o <= 1'b1;
                        end
                        S_HD: begin
                            if (output_params_flag_o) begin // [RULE_13]
                                state_reg <= S_OUT;
                                left_reg <= OUT_PARAM_BYTES + 16'h0004;
                                rreq_reg <= 1'b1;
                            end else begin
                                state_reg <= S_CFG;
                                left_reg <= CONFIG_BYTES;
                                xreq_reg <= 1'b1; // [RULE_11]
                            end
                        end
                        S_OUT: begin
                            state_reg <= S_CFG;
                            left_reg <= CONFIG_BYTES;
                            xreq_reg <= 1'b1; // [RULE_11]
                        end
                        default: state_reg <= state_reg;
                    endcase
                end
            end
            if (state_reg == S_RUN && decode_done_i) begin
                state_reg <= S_HD;
                busy_o <= 1'b0;
                left_reg <= xfer_bytes(XFER_DECISION, frame_length_o);
                rreq_reg <= 1'b1; // [RULE_01] [RULE_21]
            end
        end
    end

    // Read data: beat address echoes back so readouts are traceable
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_reg <= 64'h0;
        end else if (out_win) begin
            rdata_reg <= {32'h0, link.addr};
        end
    end

    assign link.decoder_transmit_request = xreq_reg;
    assign link.decoder_receive_request = rreq_reg;
    assign link.rdata = rdata_reg;
endmodule

// ### hw/dec_dma_sequencer.sv
// DMA end: chained transfers per user channel, paced by decoder events
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// [RULE_01] Event 30 paces result reads
// [RULE_02] Event 31 paces input writes
// [RULE_03] Every transfer moves whole 8-byte beats
// [RULE_04] Config: 64 bytes to base word
// [RULE_05] Config chains straight into symbol load
// [RULE_06] Symbols: 8*ceil(FL/2) bytes to memory
// [RULE_07] Interleave flag chains to table load
// [RULE_08] Else chain to next pending config
// [RULE_09] Table: 8*ceil((FL+3)/4) bytes loaded
// [RULE_10] After table: next config or dummy
// [RULE_11] Final transmit event fetches next config
// [RULE_12] End on dummy, never null link
// [RULE_13] Output params read only when flagged
// [RULE_14] Shared mode: a-priori except first pass
// [RULE_15] One array, one frame per event
// [RULE_16] Buffers aligned to 8-byte boundaries
// [RULE_17] Of transmit transfers, only table load raises completion flag
// [RULE_18] Flag completion after last receive transfer
// [RULE_19] Decisions: 8*ceil(FL/64) bytes read out
// [RULE_20] Output params: 12 bytes read; code reads 16, two whole beats
// [RULE_21] Events only when memory or results ready
module dec_dma_sequencer
    import dec_dma_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    dec_dma_if.dma link,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic tc_flag_o
);
    // =========================================
    // Software registers
    logic [4:0] ctrl_reg;
    logic [FL_W-1:0] frame_reg;
    logic pending_reg;
    logic done_reg;
    logic stall_reg;
    logic [15:0] chan_count_reg;
    logic busy;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_reg <= 5'h00;
            frame_reg <= '0;
        end else if (wr_i && addr_i == REG_CTRL) begin
            ctrl_reg <= wdata_i[4:0];
        end else if (wr_i && addr_i == REG_FRAME) begin
            frame_reg <= wdata_i[FL_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o <= 32'h0;
        end else if (rd_i) begin
            unique case (addr_i)
                REG_CTRL: rdata_o <= {27'h0, ctrl_reg};
                REG_FRAME: rdata_o <= {{(32-FL_W){1'b0}}, frame_reg};
                REG_STATUS: rdata_o <= {28'h0, pending_reg, stall_reg, done_reg, busy};
                REG_COUNT: rdata_o <= {16'h0, chan_count_reg};
                default: rdata_o <= 32'h0;
            endcase
        end else begin
            rdata_o <= 32'h0;
        end
    end

    // =========================================
    // Transfer engine
    xfer_kind_e kind_reg;
    logic active_reg;
    logic [15:0] left_reg;
    logic [31:0] dev_addr_reg;
    logic [31:0] mem_addr_reg;
    logic armed_tx_reg;
    logic armed_rx_reg;
    logic first_reg;
    logic kick_reg;
    logic [31:0] mem [0:63];
    logic [63:0] beat;
    logic go;
    logic xev;
    logic rev;
    logic last_beat;
    assign busy = active_reg;
    assign go = wr_i && addr_i == REG_CTRL && wdata_i[CTRL_GO_BIT];
    // A start from software stands in for the event that an idle decoder will not raise again
    assign xev = link.decoder_transmit_request || kick_reg;
    assign rev = link.decoder_receive_request;
    assign last_beat = active_reg && left_reg == 16'(BEAT_BYTES);
    assign beat = {mem[mem_addr_reg[7:2] + 6'd1], mem[mem_addr_reg[7:2]]};

    function automatic logic [31:0] dev_base(input xfer_kind_e k);
        case (k)
            XFER_CONFIG: dev_base = CONFIG_BASE_ADDR;
            XFER_SYMBOL: dev_base = SYMBOL_MEM_ADDR;
            XFER_INTERLEAVE: dev_base = INTERLEAVER_MEM_ADDR;
            XFER_DECISION: dev_base = DECISION_MEM_ADDR;
            XFER_OUTPARAM: dev_base = OUT_PARAM_ADDR;
            default: dev_base = 32'h0;
        endcase
    endfunction

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            kind_reg <= XFER_DUMMY;
            active_reg <= 1'b0;
            left_reg <= 16'h0;
            dev_addr_reg <= 32'h0;
            mem_addr_reg <= 32'h0;
            armed_tx_reg <= 1'b0;
            armed_rx_reg <= 1'b0;
            first_reg <= 1'b0;
            kick_reg <= 1'b0;
            pending_reg <= 1'b0;
            tc_flag_o <= 1'b0;
            stall_reg <= 1'b0;
            done_reg <= 1'b0;
            chan_count_reg <= 16'h0;
        end else begin
            tc_flag_o <= 1'b0;
            kick_reg <= 1'b0;
            if (go) begin
                pending_reg <= 1'b1;
                first_reg <= wdata_i[CTRL_FIRST_BIT];
                stall_reg <= 1'b0; // Software clears the stall by re-arming
                // Mid-channel starts only mark a pending channel; the final event chains to it
                if (kind_reg == XFER_DUMMY && !active_reg) begin
                    armed_tx_reg <= 1'b1;
                    kind_reg <= XFER_CONFIG;
                    kick_reg <= 1'b1;
                end
            end
            if (xev) begin
                if (armed_tx_reg && kind_reg != XFER_DUMMY) begin // [RULE_02] [RULE_15]
                    active_reg <= 1'b1;
                    armed_tx_reg <= 1'b0;
                    left_reg <= xfer_bytes(kind_reg, frame_reg); // [RULE_03] [RULE_06] [RULE_09]
                    dev_addr_reg <= dev_base(kind_reg); // [RULE_04]
                    mem_addr_reg <= 32'h0; // [RULE_16]
                    if (kind_reg == XFER_CONFIG) begin
                        pending_reg <= 1'b0;
                        armed_rx_reg <= 1'b1;
                    end
                end else if (!armed_tx_reg) begin
                    stall_reg <= 1'b1; // [RULE_12]
                end
            end
            if (rev && armed_rx_reg && !active_reg) begin // [RULE_01]
                active_reg <= 1'b1;
                left_reg <= xfer_bytes(kind_reg, frame_reg); // [RULE_19] [RULE_20]
                dev_addr_reg <= dev_base(kind_reg);
            end
            if (active_reg) begin
                left_reg <= left_reg - 16'(BEAT_BYTES);
                dev_addr_reg <= dev_addr_reg + 32'(BEAT_BYTES);
                mem_addr_reg <= mem_addr_reg + 32'(BEAT_BYTES);
            end
            if (last_beat) begin
                active_reg <= 1'b0;
                unique case (kind_reg)
                    XFER_CONFIG: begin
                        kind_reg <= XFER_SYMBOL; // [RULE_05]
                        armed_tx_reg <= 1'b1;
                    end
                    XFER_SYMBOL: begin
                        armed_tx_reg <= 1'b1;
                        if (ctrl_reg[CTRL_INTERLEAVER_LOAD_FLAG_BIT]) begin
                            kind_reg <= XFER_INTERLEAVE; // [RULE_07]
                        end else if (ctrl_reg[CTRL_SHARED_BIT] && !first_reg) begin
                            kind_reg <= XFER_APRIORI; // [RULE_14]
                        end else begin
                            kind_reg <= XFER_DECISION; // [RULE_08]
                        end
                    end
                    XFER_INTERLEAVE, XFER_APRIORI: begin
                        tc_flag_o <= kind_reg == XFER_INTERLEAVE; // [RULE_17]
                        armed_tx_reg <= 1'b1;
                        kind_reg <= XFER_DECISION; // [RULE_10]
                    end
                    XFER_DECISION: begin
                        if (ctrl_reg[CTRL_OUTPUT_PARAMS_FLAG_BIT] && !ctrl_reg[CTRL_SHARED_BIT]) begin
                            kind_reg <= XFER_OUTPARAM; // [RULE_13]
                        end else begin
                            kind_reg <= pending_reg ? XFER_CONFIG : XFER_DUMMY;
                            armed_rx_reg <= 1'b0;
                            tc_flag_o <= 1'b1; // [RULE_18]
                            done_reg <= 1'b1;
                            chan_count_reg <= chan_count_reg + 16'h1;
                            armed_tx_reg <= 1'b1; // [RULE_11] [RULE_12]
                        end
                    end
                    XFER_OUTPARAM: begin
                        kind_reg <= pending_reg ? XFER_CONFIG : XFER_DUMMY;
                        armed_rx_reg <= 1'b0;
                        tc_flag_o <= 1'b1; // [RULE_18]
                        done_reg <= 1'b1;
                        chan_count_reg <= chan_count_reg + 16'h1;
                        armed_tx_reg <= 1'b1; // [RULE_12]
                    end
                    default: kind_reg <= kind_reg;
                endcase
            end
            if (rd_i && addr_i == REG_STATUS && !last_beat) begin
                done_reg <= 1'b0;
            end
        end
    end

    // Buffer in processor memory, one word per software write above the map
    always_ff @(posedge clk_i) begin
        if (wr_i && addr_i[3]) begin
            mem[{3'h0, addr_i[2:0]}] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            link.addr <= 32'h0;
            link.wdata <= 64'h0;
            link.wr <= 1'b0;
            link.rd <= 1'b0;
        end else begin
            link.addr <= dev_addr_reg;
            link.wdata <= beat;
            link.wr <= active_reg && kind_reg inside {XFER_CONFIG, XFER_SYMBOL,
                XFER_INTERLEAVE, XFER_APRIORI};
            link.rd <= active_reg && kind_reg inside {XFER_DECISION, XFER_OUTPARAM};
        end
    end
endmodule

// ### tb/dec_dma_chk.sv
// Concurrent checks on the link between the decoder end and the sequencer end
`timescale 1ns/1ps
module dec_dma_chk (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic decoder_transmit_request,
    input wire logic decoder_receive_request,
    input wire logic [31:0] addr,
    input wire logic [63:0] wdata,
    input wire logic [63:0] rdata,
    input wire logic wr,
    input wire logic rd
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    // ==========================================
    // Beat runs inside one target memory
    sequence wr_run_s;
        wr ##1 (wr && addr[31:16] == $past(addr[31:16]));
    endsequence
    sequence rd_run_s;
        rd ##1 (rd && addr[31:16] == $past(addr[31:16]));
    endsequence

    // ==========================================
    // Link rules
    a_one_direction: assert property (!(wr && rd))
        else $error("write and read beats at once");
    a_beat_aligned: assert property ((wr || rd) |-> addr[2:0] == 3'h0)
        else $error("beat address not on an 8-byte boundary");
    a_write_region: assert property (wr |-> addr[31:16] inside {16'h5000, 16'h5001, 16'h5005})
        else $error("write beat outside the input memories");
    a_config_window: assert property (wr && addr[31:16] == 16'h5000 |-> addr[15:0] <= 16'h0038)
        else $error("config write beyond 64 bytes");
    a_read_region: assert property (rd |-> addr[31:16] == 16'h5006
        || (addr[31:16] == 16'h5000 && addr[15:0] inside {16'h0030, 16'h0038}))
        else $error("read beat outside the result memories");
    a_write_step: assert property (wr_run_s |-> addr == $past(addr) + 32'h8)
        else $error("write beats not contiguous");
    a_read_step: assert property (rd_run_s |-> addr == $past(addr) + 32'h8)
        else $error("read beats not contiguous");
    a_xmit_pulse: assert property ($rose(decoder_transmit_request) |=> !decoder_transmit_request)
        else $error("transmit request longer than one cycle");
    a_recv_pulse: assert property ($rose(decoder_receive_request) |=> !decoder_receive_request)
        else $error("receive request longer than one cycle");
endmodule

// ### tb/tb_turbo_decoder_dma_sequencing.sv
// Self-checking bench: both link ends joined, channels run through the sequencer registers
`timescale 1ns/1ps
module tb_turbo_decoder_dma_sequencing;
    import dec_dma_pkg::*;
    typedef struct packed {xfer_kind_e kind; logic [15:0] bytes;} xfer_s;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic decode_done_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rd_d = 1'b0;
    logic [31:0] rdata_o;
    logic tc_flag_o;
    logic [FL_W-1:0] frame_length_o;
    logic interleaver_load_flag_o;
    logic output_params_flag_o;
    logic busy_o;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    int tc_count = 0;
    xfer_s xfer_q[$];
    logic [63:0] rd_q[$];
    logic [63:0] rd_note;
    xfer_kind_e cur_kind = XFER_DUMMY;
    logic [15:0] cur_bytes = 16'h0;
    dec_dma_if link();
    dec_event_source dec_event_source_i (.clk_i(clk_i), .reset_i(reset_i), .link(link),
        .decode_done_i(decode_done_i), .frame_length_o(frame_length_o),
        .interleaver_load_flag_o(interleaver_load_flag_o),
        .output_params_flag_o(output_params_flag_o), .busy_o(busy_o));
    dec_dma_sequencer dec_dma_sequencer_i (.clk_i(clk_i), .reset_i(reset_i), .link(link),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .tc_flag_o(tc_flag_o));
    dec_dma_chk dec_dma_chk_i (.clk_i(clk_i), .reset_i(reset_i),
        .decoder_transmit_request(link.decoder_transmit_request),
        .decoder_receive_request(link.decoder_receive_request), .addr(link.addr),
        .wdata(link.wdata), .rdata(link.rdata), .wr(link.wr), .rd(link.rd));
    always #12.5 clk_i = ~clk_i;

    // ==========================================
    // Compare and report
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // A transfer is closed when the next one starts at its base or at the end
    task automatic flush();
        xfer_s e;
        e = '{XFER_DUMMY, 16'h0};
        if (cur_bytes != 16'h0) begin
            if (xfer_q.size() > 0) e = xfer_q.pop_front();
            check("transfer kind", 32'(e.kind), 32'(cur_kind));
            check("transfer bytes", 32'(e.bytes), 32'(cur_bytes));
        end
        cur_bytes = 16'h0;
    endtask

    // ==========================================
    // Watchers: link beats, register reads, completion pulses, hang limit
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            $display("ERROR timeout expected finish seen hang");
            results();
        end
        if (tc_flag_o === 1'b1) tc_count++;
        if (rd_d) begin
            rd_note = rd_q.pop_front();
            check("register read", rd_note[31:0], rdata_o & rd_note[63:32]);
        end
        rd_d = rd_i;
        if (link.wr === 1'b1 || link.rd === 1'b1) begin
            // Close the previous transfer before naming the new one
            if (link.addr[15:0] == 16'h0 || (link.rd === 1'b1 && link.addr[15:0] == 16'h30)) begin
                flush();
                case ({link.wr, link.addr[19:16]})
                    5'h10: cur_kind = XFER_CONFIG;
                    5'h11: cur_kind = XFER_SYMBOL;
                    5'h15: cur_kind = XFER_INTERLEAVE;
                    5'h06: cur_kind = XFER_DECISION;
                    default: cur_kind = XFER_OUTPARAM;
                endcase
            end
            cur_bytes = cur_bytes + 16'h8;
        end
    end

    // ==========================================
    // Register port and channel drivers
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
        rd_q.push_back({mask, exp});
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    // Waits out a burst; events follow within two cycles, so 40 quiet cycles close it
    task automatic wait_idle();
        int quiet;
        quiet = 0;
        while (quiet < 40) begin
            @(posedge clk_i);
            quiet = (link.wr === 1'b1 || link.rd === 1'b1) ? 0 : quiet + 1;
        end
    endtask
    task automatic run_channel(input int fl, input logic interleaver_load_flag, input logic output_params_flag);
        xfer_q.push_back('{XFER_CONFIG, 16'h40});
        xfer_q.push_back('{XFER_SYMBOL, 16'(8 * ((fl + 1) / 2))});
        if (interleaver_load_flag) xfer_q.push_back('{XFER_INTERLEAVE, 16'(8 * ((fl + 6) / 4))});
        xfer_q.push_back('{XFER_DECISION, 16'(8 * ((fl + 63) / 64))});
        if (output_params_flag) xfer_q.push_back('{XFER_OUTPARAM, 16'h10});
        tc_count = 0;
        reg_wr(REG_FRAME, 32'(fl));
        // Config word 0: frame length low, flag bits in the high word
        reg_wr(4'h8, 32'(fl));
        reg_wr(4'h9, {30'h0, output_params_flag, interleaver_load_flag});
        reg_wr(REG_CTRL, {29'h0, output_params_flag, interleaver_load_flag, 1'b1});
        wait_idle();
        check("frame length", 32'(fl), 32'(frame_length_o));
        check("interleave flag", {31'h0, interleaver_load_flag}, {31'h0, interleaver_load_flag_o});
        check("out param flag", {31'h0, output_params_flag}, {31'h0, output_params_flag_o});
        check("completion pulses", {31'h0, interleaver_load_flag}, 32'(tc_count));
        check("decoder busy", 32'h1, {31'h0, busy_o});
        @(posedge clk_i);
        decode_done_i <= 1'b1;
        @(posedge clk_i);
        decode_done_i <= 1'b0;
        wait_idle();
        check("decoder busy", 32'h0, {31'h0, busy_o});
        check("completion pulses", {31'h0, interleaver_load_flag} + 32'h1, 32'(tc_count));
        reg_rd(REG_FRAME, 32'hffff, 32'(fl));
    endtask

    // ==========================================
    // Main sequence
    initial begin
        int fl;
        void'($urandom(32'hec97bc8a));
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        reg_rd(REG_STATUS, 32'h4, 32'h4);
        for (int c = 0; c < 6; c++) begin
            fl = (c == 0) ? 1 : (c == 1) ? 64 : (c == 2) ? 65 : 2 + $urandom % 300;
            run_channel(fl, c[0], c[1]);
            reg_rd(REG_STATUS, 32'hf, 32'h2);
            reg_rd(REG_COUNT, 32'hffff, 32'(c + 1));
        end
        reg_wr(4'h7, 32'hffff_ffff);
        reg_rd(4'h7, 32'hffff_ffff, 32'h0);
        reg_rd(REG_FRAME, 32'hffff, 32'(fl));
        repeat (4) @(posedge clk_i);
        flush();
        check("transfers left", 32'h0, 32'(xfer_q.size()));
        results();
    end
endmodule
